/* File: hdl/host_controller_control_flags.sv */
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "hc_flags_map.svh"
// Summary of operation
// - rom valid set lets physical unit answer config ROM block reads.
// - rom valid clear makes config ROM block reads get ack_type_error unless tardy enable is set.
// - bus reset with rom valid clear leaves 34h, 18h, 20h untouched.
// - rom valid clears only by hardware reset, soft reset, fetch error.
// - swap disable bit 30 steers DMA byte swapping.
// - tardy enable bit 29 makes node answer async packets with ack_tardy.
// - every ack_tardy sent pulses interrupt event bit 27.
// - bits 28-24 always read zero.
// - bit 23 loads from EEPROM, software may only clear it.
// - bits 21-20 always read zero.
// - link-PHY traffic allowed only while link power status is one.
// - set register at 50h, clear register at 54h.
// - link enable zero stops all acks and config ROM reads; bus reset still updates ROM registers.
module host_controller_control_flags
	import hc_flags_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic soft_reset,
	input wire logic fetch_error,
	input wire logic eeprom_load,
	input wire logic eeprom_prog_phy,
	input wire logic link_active_enable,
	input wire logic bus_reset,
	input wire rx_req_type rx_req,
	output ack_kind_type ack_kind,
	output logic ack_is_tardy,
	output logic tardy_event,
	output logic rom_regs_update,
	output logic rom_read_enable,
	output logic dma_byte_swap,
	output logic phy_link_enable,
	output logic enhancements_on
);
	// reset image kept as a constant so the reset branch assigns literals only
	localparam logic [31:0] RESET_IMAGE = `HCF_RESET_VALUE;

	// one register per flag; each flag is owned by exactly one process so
	// that no variable ends up with two drivers
	logic rom_valid_q;
	logic swap_disable_q;
	logic tardy_enable_q;
	logic prog_phy_q;
	logic enhance_on_q;
	logic link_power_q;

	// gathered copy of all flags, used by the read view and the decisions
	hc_flags_type flags;

	// decoded write strobes of the set/clear pair
	logic set_hit;
	logic clr_hit;

	// decoded read strobe for either address of the pair
	logic rd_hit;

	// the full 32-bit word as software sees it
	logic [31:0] view;

	// decode of the set/clear pair; both offsets share one write strobe,
	// so a set and a clear can never land in the same cycle
	always_comb begin
		set_hit = 1'b0;
		clr_hit = 1'b0;
		if (wr && addr == `HCF_SET_OFFSET) begin
			set_hit = 1'b1;
		end else if (wr && addr == `HCF_CLR_OFFSET) begin
			clr_hit = 1'b1;
		end
	end

	// read decode: either address of the pair returns the same view
	always_comb begin
		rd_hit = 1'b0;
		if (rd && addr == `HCF_SET_OFFSET) begin
			rd_hit = 1'b1;
		end else if (rd && addr == `HCF_CLR_OFFSET) begin
			rd_hit = 1'b1;
		end
	end

	// rom valid: software may set it, only resets or fetch errors clear it;
	// a write of one to the clear address is ignored on purpose, because a
	// driver clearing it by mistake would silently break config ROM reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rom_valid_q <= RESET_IMAGE[`HCF_BIT_ROM_VALID];
		end else if (soft_reset) begin
			rom_valid_q <= 1'b0;
		end else if (fetch_error) begin
			rom_valid_q <= 1'b0;
		end else if (set_hit && wdata[`HCF_BIT_ROM_VALID]) begin
			rom_valid_q <= 1'b1;
		end
	end

	// swap disable: plain set/clear flag, soft reset returns it to zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			swap_disable_q <= RESET_IMAGE[`HCF_BIT_SWAP_DIS];
		end else if (soft_reset) begin
			swap_disable_q <= 1'b0;
		end else if (set_hit && wdata[`HCF_BIT_SWAP_DIS]) begin
			swap_disable_q <= 1'b1;
		end else if (clr_hit && wdata[`HCF_BIT_SWAP_DIS]) begin
			swap_disable_q <= 1'b0;
		end
	end

	// tardy enable: plain set/clear flag; keeping it clear while this node
	// manages the bus is left to software
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tardy_enable_q <= RESET_IMAGE[`HCF_BIT_TARDY_EN];
		end else if (soft_reset) begin
			tardy_enable_q <= 1'b0;
		end else if (set_hit && wdata[`HCF_BIT_TARDY_EN]) begin
			tardy_enable_q <= 1'b1;
		end else if (clr_hit && wdata[`HCF_BIT_TARDY_EN]) begin
			tardy_enable_q <= 1'b0;
		end
	end

	// enhancement enable: the flag itself is plain set/clear; the gating
	// with the eeprom flag happens on the output level further down
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enhance_on_q <= RESET_IMAGE[`HCF_BIT_ENH_ON];
		end else if (soft_reset) begin
			enhance_on_q <= 1'b0;
		end else if (set_hit && wdata[`HCF_BIT_ENH_ON]) begin
			enhance_on_q <= 1'b1;
		end else if (clr_hit && wdata[`HCF_BIT_ENH_ON]) begin
			enhance_on_q <= 1'b0;
		end
	end

	// link power status: plain set/clear flag; software must let the phy
	// side clock settle after setting it, nothing here waits for that
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link_power_q <= RESET_IMAGE[`HCF_BIT_LPS];
		end else if (soft_reset) begin
			link_power_q <= 1'b0;
		end else if (set_hit && wdata[`HCF_BIT_LPS]) begin
			link_power_q <= 1'b1;
		end else if (clr_hit && wdata[`HCF_BIT_LPS]) begin
			link_power_q <= 1'b0;
		end
	end

	// eeprom-loaded flag: a load wins over a clear in the same cycle, a
	// set write has no path here at all, and soft reset leaves it alone
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prog_phy_q <= RESET_IMAGE[`HCF_BIT_PROG_PHY];
		end else if (eeprom_load) begin
			prog_phy_q <= eeprom_prog_phy;
		end else if (clr_hit && wdata[`HCF_BIT_PROG_PHY]) begin
			prog_phy_q <= 1'b0;
		end
	end

	// gather the flags into one carrier for the logic below
	always_comb begin
		flags.rom_valid = rom_valid_q;
		flags.swap_disable = swap_disable_q;
		flags.tardy_enable = tardy_enable_q;
		flags.prog_phy = prog_phy_q;
		flags.enhance_on = enhance_on_q;
		flags.link_power = link_power_q;
	end

	// reserved bits are built in as constant zeros; the low half belongs to
	// other logic and reads zero from this block
	always_comb begin
		view = 32'h00000000;
		view[`HCF_BIT_ROM_VALID] = flags.rom_valid;
		view[`HCF_BIT_SWAP_DIS] = flags.swap_disable;
		view[`HCF_BIT_TARDY_EN] = flags.tardy_enable;
		view[`HCF_BIT_PROG_PHY] = flags.prog_phy;
		view[`HCF_BIT_ENH_ON] = flags.enhance_on;
		view[`HCF_BIT_LPS] = flags.link_power;
	end

	// read data in the cycle after the strobe only; unmapped reads zero,
	// so a stale word can never be mistaken for a fresh answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (rd_hit) begin
			rdata <= view;
		end else begin
			rdata <= 32'h00000000;
		end
	end

	// acknowledge decision for each received request, one cycle later;
	// tardy has priority because a sleeping host cannot serve anything,
	// not even a config ROM read with a valid image
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_kind <= ACK_NONE;
			ack_is_tardy <= 1'b0;
			tardy_event <= 1'b0;
		end else begin
			ack_kind <= ACK_NONE;
			ack_is_tardy <= 1'b0;
			tardy_event <= 1'b0;
			if (rx_req.valid && link_active_enable) begin
				if (flags.tardy_enable) begin
					ack_kind <= ACK_TYPE_ERR_OR_TARDY;
					ack_is_tardy <= 1'b1;
					tardy_event <= 1'b1;
				end else if (rx_req.rom_block_read && !flags.rom_valid) begin
					ack_kind <= ACK_TYPE_ERR_OR_TARDY;
				end else begin
					ack_kind <= ACK_NORMAL;
				end
			end
		end
	end

	// bus reset updates the rom shadow registers only with a valid image
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rom_regs_update <= 1'b0;
		end else begin
			rom_regs_update <= bus_reset && flags.rom_valid;
		end
	end

	// config rom block reads are served only with a valid image and a
	// connected link
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rom_read_enable <= 1'b0;
		end else begin
			rom_read_enable <= flags.rom_valid && link_active_enable;
		end
	end

	// byte swapping is on unless software disables it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dma_byte_swap <= 1'b1;
		end else begin
			dma_byte_swap <= !flags.swap_disable;
		end
	end

	// link-phy traffic follows the power status flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phy_link_enable <= 1'b0;
		end else begin
			phy_link_enable <= flags.link_power;
		end
	end

	// enhancements stay off unless the eeprom flag allows them, which
	// guards against a driver that set the bit without permission
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enhancements_on <= 1'b0;
		end else begin
			enhancements_on <= flags.enhance_on && flags.prog_phy;
		end
	end
endmodule : host_controller_control_flags

/* File: hdl/hc_flags_map.svh */
`ifndef HC_FLAGS_MAP_SVH
`define HC_FLAGS_MAP_SVH
// register offsets (byte addresses)
`define HCF_SET_OFFSET 8'h50
`define HCF_CLR_OFFSET 8'h54
// field positions
`define HCF_BIT_ROM_VALID 31
`define HCF_BIT_SWAP_DIS 30
`define HCF_BIT_TARDY_EN 29
`define HCF_BIT_PROG_PHY 23
`define HCF_BIT_ENH_ON 22
`define HCF_BIT_LPS 19
`define HCF_BIT_LINK_EN 17
// nominal write masks, unused by the module; bit 31 can be set but not cleared, unlike these
`define HCF_SET_MASK 32'h60480000
`define HCF_CLR_MASK 32'hE0C80000
// reset value of the whole register
`define HCF_RESET_VALUE 32'h00800000
`endif

/* File: hdl/hc_flags_pkg.sv */
package hc_flags_pkg;
	// flags held by the register, low half stays outside this block
	typedef struct packed {
		logic rom_valid;
		logic swap_disable;
		logic tardy_enable;
		logic prog_phy;
		logic enhance_on;
		logic link_power;
	} hc_flags_type;

	// request from the 1394 receive side
	typedef struct packed {
		logic valid;
		logic rom_block_read;
		logic to_self;
	} rx_req_type;

	// answer chosen by this block
	typedef enum logic [2:0] {
		ACK_NONE = 3'b001,
		ACK_NORMAL = 3'b010,
		ACK_TYPE_ERR_OR_TARDY = 3'b100
	} ack_kind_type;
endpackage : hc_flags_pkg

/* File: testbench/host_controller_control_flags_assertions.sv */
`timescale 1ns/100ps
module hcf_checker
	import hc_flags_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic rd,
	input wire logic [31:0] rdata,
	input wire logic link_active_enable,
	input wire logic bus_reset,
	input wire rx_req_type rx_req,
	input wire ack_kind_type ack_kind,
	input wire logic ack_is_tardy,
	input wire logic tardy_event,
	input wire logic rom_regs_update,
	input wire logic rom_read_enable,
	input wire logic dma_byte_swap,
	input wire logic phy_link_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// read view and the level outputs must agree on rom valid, swap disable and link power; reserved bits read zero
	AST_RSVD_HIGH: assert property (rd |=> rdata[28:24] == 5'h00) else $error("bits 28-24 set");
	AST_RSVD_LOW: assert property (rd |=> rdata[21:20] == 2'h0) else $error("bits 21-20 set");
	AST_ROM_LEVEL: assert property (rd |=> rom_read_enable == (rdata[31] && $past(link_active_enable)))
		else $error("rom level");
	AST_SWAP_LEVEL: assert property (rd |=> rdata[30] == !dma_byte_swap) else $error("swap");
	AST_LPS_LEVEL: assert property (rd |=> rdata[19] == phy_link_enable) else $error("lps");
	// every tardy answer is recorded as an event in the same cycle
	AST_TARDY_EVENT: assert property (ack_is_tardy |-> tardy_event && ack_kind == ACK_TYPE_ERR_OR_TARDY)
		else $error("tardy event missing");
	AST_BUS_RESET: assert property (bus_reset && link_active_enable |=> rom_regs_update == rom_read_enable)
		else $error("rom regs update");
	// a disabled link must stay silent, no answer and no event
	AST_LINK_OFF: assert property (rx_req.valid && !link_active_enable |=> ack_kind == ACK_NONE && !tardy_event)
		else $error("answer while link off");
endmodule : hcf_checker
bind host_controller_control_flags hcf_checker i_chk (.*);

/* File: testbench/host_controller_control_flags_tb_top.sv */
`timescale 1ns/100ps
module host_controller_control_flags_tb_top import hc_flags_pkg::*;;
	logic clk = 0, rst = 1, wr = 0, rd = 0, link = 0, tardy;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic tev, upd;
	logic [3:0] lvl; // rom read enable, enhancements, phy link, byte swap
	logic [3:0] side_q = 4'h0; // soft reset, fetch error, eeprom load, bus reset
	rx_req_type rx_req = '0;
	ack_kind_type ack_kind;
	int num_errors = 0, num_checks = 0;
	initial forever #25 clk = ~clk;
	host_controller_control_flags i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .soft_reset(side_q[0]), .fetch_error(side_q[1]),
		.eeprom_load(side_q[2]), .eeprom_prog_phy(1'b1), .link_active_enable(link),
		.bus_reset(side_q[3]), .rx_req(rx_req), .ack_kind(ack_kind), .ack_is_tardy(tardy),
		.tardy_event(tev), .rom_regs_update(upd), .rom_read_enable(lvl[3]),
		.dma_byte_swap(lvl[0]), .phy_link_enable(lvl[1]), .enhancements_on(lvl[2]));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr
	// low half belongs to other logic, so only bits 31-19 are compared
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("flags", exp, rdata & 32'hFFF80000);
	endtask : reg_rd
	task automatic rx(input rx_req_type r, input ack_kind_type exp, input logic t);
		@(posedge clk);
		rx_req <= r;
		@(posedge clk);
		rx_req <= '0;
		@(negedge clk);
		chk("ack", {27'h0, t, t, exp}, {27'h0, tev, tardy, ack_kind});
	endtask : rx
	task automatic side(input logic [3:0] v);
		@(posedge clk);
		side_q <= v;
		@(posedge clk);
		side_q <= 4'h0;
	endtask : side
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		reg_rd(8'h50, 32'h00800000);
		reg_wr(8'h50, 32'hFFB80000);
		reg_wr(8'h58, 32'hFFFFFFFF);
		reg_wr(8'h54, 32'h80000000);
		reg_rd(8'h54, 32'hE0880000);
		chk("levels", 32'h00000002, {28'h0, lvl});
		side(4'h8);
		@(negedge clk);
		chk("rom update", 32'h00000001, {31'h0, upd});
		rx(3'b110, ACK_NONE, 1'b0);
		$display("access test done");
		link <= 1'b1;
		reg_wr(8'h54, 32'h20000000);
		rx(3'b110, ACK_NORMAL, 1'b0);
		chk("levels", 32'h0000000A, {28'h0, lvl});
		side(4'h2);
		rx(3'b110, ACK_TYPE_ERR_OR_TARDY, 1'b0);
		reg_wr(8'h50, 32'h20000000);
		rx(3'b101, ACK_TYPE_ERR_OR_TARDY, 1'b1);
		$display("ack test done");
		reg_wr(8'h54, 32'hFFFFFFFF);
		reg_wr(8'h50, 32'h00800000);
		reg_rd(8'h50, 32'h00000000);
		side(4'hC);
		@(negedge clk);
		chk("rom update", 32'h00000000, {31'h0, upd});
		reg_wr(8'h50, 32'h00480000);
		reg_rd(8'h54, 32'h00C80000);
		chk("levels", 32'h00000007, {28'h0, lvl});
		side(4'h1);
		reg_rd(8'h50, 32'h00800000);
		chk("levels", 32'h00000001, {28'h0, lvl});
		$display("reset test done");
		tally_and_finish();
	end
endmodule : host_controller_control_flags_tb_top
